// file: hdl/apms_params.svh
// Constants of the ADC power-mode sequencer: field positions, reset values, timing.
// Assumes a single system clock whose rate is given here in MHz.
`ifndef APMS_PARAMS_SVH
`define APMS_PARAMS_SVH

`define APMS_CLK_MHZ 100
`define APMS_CTRL_W 8
`define APMS_CTRL_RESET 8'h00
`define APMS_PM_HI_BIT 1
`define APMS_PM_LO_BIT 0
`define APMS_MODE_CS_CTRL 2'h0
`define APMS_MODE_NORMAL 2'h1
`define APMS_MODE_AUTO_SHUT 2'h2
`define APMS_MODE_AUTO_STBY 2'h3
`define APMS_CTRL_EDGES 5'h08
`define APMS_SAMPLE_EDGE 5'h02
`define APMS_XFER_EDGES 5'h10
`define APMS_WAKE_SHUT_NS 5000
`define APMS_WAKE_STBY_NS 1000
`define APMS_WAKE_SHUT_CYC ((`APMS_WAKE_SHUT_NS * `APMS_CLK_MHZ + 999) / 1000)
`define APMS_WAKE_STBY_CYC ((`APMS_WAKE_STBY_NS * `APMS_CLK_MHZ + 999) / 1000)
`define APMS_WAKE_W 10

`endif

// file: hdl/apms_pkg.sv
// Types shared by the ADC power-mode sequencer modules.
// Assumes apms_params.svh is on the include path.
`include "apms_params.svh"

package apms_pkg;

    typedef enum logic [1:0] {
        APMS_PWR_OFF,
        APMS_PWR_STANDBY,
        APMS_PWR_WAKING,
        APMS_PWR_ON
    } apms_pwr_t;

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
        logic [1:0] prev;
    } apms_sync_t;

    typedef struct packed {
        apms_pwr_t pwr;
        logic [`APMS_WAKE_W-1:0] wake_cnt;
        logic [4:0] rise_cnt;
        logic fall_seen;
        logic [`APMS_CTRL_W-1:0] shift;
        logic [`APMS_CTRL_W-1:0] ctrl;
        logic sample;
        logic done;
        logic abort;
        logic early;
    } apms_state_t;

endpackage

// file: hdl/apms_link_if.sv
// Carrier for the synchronised serial-link events between the sequencer's modules.
// Assumes all signals are on sys_clk.
`timescale 1ns/100ps
`default_nettype none

interface apms_link_if;
    logic cs_low;
    logic din;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    modport src (output cs_low, output din, output cs_fall, output cs_rise, output sclk_rise, output sclk_fall);
    modport dst (input cs_low, input din, input cs_fall, input cs_rise, input sclk_rise, input sclk_fall);
endinterface

`default_nettype wire

// file: hdl/apms_link_sync.sv
// Two-flop synchronisers for the serial pins and edge detection on the system clock.
// Assumes sys_clk runs well above twice the serial clock rate.
`timescale 1ns/100ps
`default_nettype none

module apms_link_sync
    import apms_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    apms_link_if.src lk
);

    apms_sync_t r;
    apms_sync_t next_r;

    // Bit 2 is chip select, bit 1 the serial clock, bit 0 the data; the first stage
    // feeds only the second so a metastable sample never reaches the edge logic.
    always_comb begin
        next_r = r;
        next_r.stage1 = {cs_n, sclk, din};
        next_r.stage2 = r.stage1;
        next_r.prev = r.stage2[2:1];
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '{stage1: 3'h6, stage2: 3'h6, prev: 2'h3};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign lk.cs_low = ~r.stage2[2];
    assign lk.din = r.stage2[0];
    assign lk.cs_fall = r.prev[1] & ~r.stage2[2];
    assign lk.cs_rise = ~r.prev[1] & r.stage2[2];
    assign lk.sclk_rise = ~r.prev[0] & r.stage2[1];
    assign lk.sclk_fall = r.prev[0] & ~r.stage2[1];

endmodule // apms_link_sync

`default_nettype wire

// file: hdl/apms_seq.sv
// Power-mode sequencer of a serial ADC: loads the control byte from the link and
// powers the converter up and down on chip-select and serial-clock edges.
// Assumes the serial pins are asynchronous to sys_clk and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "apms_params.svh"

module apms_seq
    import apms_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic ext_ref,
    output var apms_pwr_t power_state,
    output logic [`APMS_CTRL_W-1:0] ctrl_reg,
    output logic power_mode_hi,
    output logic power_mode_lo,
    output logic sample_pulse,
    output logic conv_done,
    output logic conv_abort,
    output logic sample_early
);

    // ----------------------------------------------------------------------
    // Link synchronisation
    // ----------------------------------------------------------------------

    // Every serial pin passes the synchronisers first, so each link event reaches the
    // sequencer two system clocks after the pin moves.
    apms_link_if lk();

    apms_link_sync u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .cs_n(cs_n),
        .sclk(sclk),
        .din(din),
        .lk(lk.src)
    );

    // ----------------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------------

    // Wake times are rounded up to whole system clocks, so a wake never ends early.
    localparam logic [`APMS_WAKE_W-1:0] WAKE_SHUT = `APMS_WAKE_W'(`APMS_WAKE_SHUT_CYC);
    localparam logic [`APMS_WAKE_W-1:0] WAKE_STBY = `APMS_WAKE_W'(`APMS_WAKE_STBY_CYC);

    apms_state_t r;
    apms_state_t next_r;
    logic [1:0] mode;

    // The external reference skips the slow reference settling, so it wakes as fast
    // as standby does.
    function automatic logic [`APMS_WAKE_W-1:0] wake_time(input apms_pwr_t from, input logic ext);
        wake_time = (from == APMS_PWR_STANDBY || ext) ? WAKE_STBY : WAKE_SHUT;
    endfunction

    // Off and standby both need a full wake before the converter may sample; a wake
    // already under way is left to finish.
    function automatic logic powered_down(input apms_pwr_t p);
        powered_down = (p == APMS_PWR_OFF) || (p == APMS_PWR_STANDBY);
    endfunction

    // Both automatic modes share the upper mode bit; they differ only in how deep the
    // converter sleeps once a conversion ends.
    function automatic logic auto_mode(input logic [1:0] m);
        auto_mode = m[1];
    endfunction

    assign mode = {r.ctrl[`APMS_PM_HI_BIT], r.ctrl[`APMS_PM_LO_BIT]};

    always_comb begin
        next_r = r;
        next_r.sample = 1'b0;
        next_r.done = 1'b0;
        next_r.abort = 1'b0;
        next_r.early = 1'b0;

        // The wake counter runs down on its own; a later branch may still cut the
        // wake short, since a power-down decision outranks an unfinished wake.
        unique case (r.pwr)
            APMS_PWR_WAKING: begin
                if (r.wake_cnt <= `APMS_WAKE_W'(1)) begin
                    next_r.pwr = APMS_PWR_ON;
                end else begin
                    next_r.wake_cnt = r.wake_cnt - `APMS_WAKE_W'(1);
                end
            end
            APMS_PWR_OFF, APMS_PWR_STANDBY, APMS_PWR_ON: begin
            end
        endcase

        // Normal mode needs no link event: once loaded it wakes the converter and keeps
        // it awake whatever select does.
        if (mode == `APMS_MODE_NORMAL && powered_down(r.pwr)) begin
            next_r.pwr = APMS_PWR_WAKING;
            next_r.wake_cnt = wake_time(r.pwr, ext_ref);
        end

        // Select edges take priority over a serial clock edge found in the same cycle.
        if (lk.cs_fall) begin
            next_r.rise_cnt = 5'h00;
            next_r.fall_seen = 1'b0;
            if (mode == `APMS_MODE_CS_CTRL && powered_down(r.pwr)) begin
                next_r.pwr = APMS_PWR_WAKING;
                next_r.wake_cnt = wake_time(r.pwr, ext_ref);
            end
        end else if (lk.cs_rise) begin
            // In the automatic modes a select edge only restarts the count; a conversion
            // cut here simply never reports done.
            if (mode == `APMS_MODE_CS_CTRL) begin
                next_r.pwr = APMS_PWR_OFF;
                next_r.abort = (r.rise_cnt >= `APMS_SAMPLE_EDGE);
            end
            next_r.rise_cnt = 5'h00;
            next_r.fall_seen = 1'b0;
        end else if (lk.cs_low) begin
            // Only the first falling edge of a conversion may start a wake; done clears the flag,
            // so with select still low the next falling edge can wake the converter again.
            if (lk.sclk_fall && !r.fall_seen) begin
                next_r.fall_seen = 1'b1;
                if (auto_mode(mode) && powered_down(r.pwr)) begin
                    next_r.pwr = APMS_PWR_WAKING;
                    next_r.wake_cnt = wake_time(r.pwr, ext_ref);
                end
            end

            if (lk.sclk_rise) begin
                next_r.rise_cnt = r.rise_cnt + 5'h01;
                if (r.rise_cnt < `APMS_CTRL_EDGES) begin
                    next_r.shift = {r.shift[`APMS_CTRL_W-2:0], lk.din};
                end
                // The whole byte lands at once at the eighth edge, so a transfer cut
                // short leaves the previous mode in force.
                if (r.rise_cnt == `APMS_CTRL_EDGES - 5'h01) begin
                    next_r.ctrl = {r.shift[`APMS_CTRL_W-2:0], lk.din};
                end
                // The early flag tells the host that it sampled before the wake was over.
                if (r.rise_cnt == `APMS_SAMPLE_EDGE - 5'h01) begin
                    next_r.sample = 1'b1;
                    next_r.early = (r.pwr != APMS_PWR_ON);
                end
                // Select held low starts a fresh conversion, so the count wraps here.
                if (r.rise_cnt == `APMS_XFER_EDGES - 5'h01) begin
                    next_r.done = 1'b1;
                    next_r.rise_cnt = 5'h00;
                    next_r.fall_seen = 1'b0;
                    if (mode == `APMS_MODE_AUTO_SHUT) begin
                        next_r.pwr = APMS_PWR_OFF;
                    end else if (mode == `APMS_MODE_AUTO_STBY) begin
                        next_r.pwr = APMS_PWR_STANDBY;
                    end
                end
            end
        end
    end

    // While ce is low every field holds; link edges that pass meanwhile are not seen.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '{
                pwr: APMS_PWR_OFF,
                wake_cnt: '0,
                rise_cnt: 5'h00,
                fall_seen: 1'b0,
                shift: '0,
                ctrl: `APMS_CTRL_RESET,
                sample: 1'b0,
                done: 1'b0,
                abort: 1'b0,
                early: 1'b0
            };
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------

    // Every output is a field of the state register, so each comes straight from a
    // flip-flop and no glitch of the next-state logic reaches a pin; the price is one
    // cycle of latency after each link event.
    assign power_state = r.pwr;
    assign ctrl_reg = r.ctrl;
    assign power_mode_hi = r.ctrl[`APMS_PM_HI_BIT];
    assign power_mode_lo = r.ctrl[`APMS_PM_LO_BIT];
    assign sample_pulse = r.sample;
    assign conv_done = r.done;
    assign conv_abort = r.abort;
    assign sample_early = r.early;

endmodule // apms_seq

`default_nettype wire

// file: verif/apms_host_model.sv
// Host serial port model: frames chip select, serial clock and data in.
// Assumes the bench calls xfer between frames; pins stand still outside frames.
`timescale 1ns/100ps
`default_nettype none
module apms_host_model (
    input wire logic sys_clk,
    output logic cs_n,
    output logic sclk,
    output logic din
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    task automatic half(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // The wait w stretches the first low phase, so it covers both wake-up windows.
    task automatic xfer(input logic [7:0] b, input int n, input int w, input logic [7:0] fill);
        cs_n = 1'b0;
        half(8);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            din = (i < 8) ? b[7 - i] : fill[i - 8];
            half((i == 0) ? 8 + w : 8);
            sclk = 1'b1;
            half(8);
        end
        cs_n = 1'b1;
        din = ~din;
    endtask
endmodule // apms_host_model
`default_nettype wire

// file: verif/apms_seq_checker.sv
// Checker for the power-mode sequencer, bound to its top module.
// Assumes ce is held high while the checks run.
`timescale 1ns/100ps
`default_nettype none
`include "apms_params.svh"
module apms_seq_checker
    import apms_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic ext_ref,
    input wire apms_pwr_t power_state,
    input wire logic [`APMS_CTRL_W-1:0] ctrl_reg,
    input wire logic power_mode_hi,
    input wire logic power_mode_lo,
    input wire logic sample_pulse,
    input wire logic sample_early,
    input wire logic conv_done,
    input wire logic conv_abort
);
    logic [9:0] wl;
    logic slow;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Only a wake from full shutdown on the internal reference is the long one.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wl <= 10'h000;
            slow <= 1'b0;
        end else if (power_state != APMS_PWR_WAKING) begin
            wl <= 10'h000;
            slow <= (power_state == APMS_PWR_OFF) && !ext_ref;
        end else begin
            wl <= wl + 10'h001;
        end
    end
    a_mode_bits: assert property ({power_mode_hi, power_mode_lo} == ctrl_reg[1:0]) else $error("mode bits");
    a_done_state: assert property (conv_done && ctrl_reg[1] |->
        power_state == (ctrl_reg[0] ? APMS_PWR_STANDBY : APMS_PWR_OFF)) else $error("state at done");
    a_normal_on: assert property (ctrl_reg[1:0] == 2'h1 && $past(power_state) == APMS_PWR_ON |->
        power_state == APMS_PWR_ON) else $error("normal mode dropped power");
    a_cs_shut: assert property (ctrl_reg[1:0] == 2'h0 && cs_n [*6] |-> power_state == APMS_PWR_OFF)
        else $error("select high but powered");
    a_abort_off: assert property (conv_abort |-> ctrl_reg[1:0] == 2'h0 && power_state == APMS_PWR_OFF)
        else $error("abort without shutdown");
    a_wake_time: assert property (power_state == APMS_PWR_ON && $past(power_state) == APMS_PWR_WAKING |->
        (slow ? (wl > 10'h1e9 && wl < 10'h1ff) : (wl > 10'h059 && wl < 10'h06f))) else $error("wake length");
    a_wake_via: assert property ($past(power_state) == APMS_PWR_OFF && power_state != APMS_PWR_OFF |->
        power_state == APMS_PWR_WAKING) else $error("skipped wake");
    a_early_ok: assert property (sample_pulse && $past(power_state, 2) == APMS_PWR_ON |-> !sample_early)
        else $error("early flag when powered");
    a_done_gap: assert property (conv_done |=> !conv_done [*8]) else $error("done too soon");
    c_abort: cover property (conv_abort);
    c_standby: cover property (conv_done && power_state == APMS_PWR_STANDBY);
    c_early: cover property (sample_early);
endmodule // apms_seq_checker
bind apms_seq apms_seq_checker chk_i (.sys_clk, .reset, .cs_n, .ext_ref, .power_state, .ctrl_reg,
    .power_mode_hi, .power_mode_lo, .sample_pulse, .sample_early, .conv_done, .conv_abort);
`default_nettype wire

// file: verif/tb_adc_power_mode_sequencer.sv
// Bench for the power-mode sequencer: a table of transfers through the host model.
// Assumes ce stays high; expected events are queued and compared by a monitor.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_power_mode_sequencer
    import apms_pkg::*;
;
    localparam apms_pwr_t pf = APMS_PWR_OFF;
    localparam apms_pwr_t ps = APMS_PWR_STANDBY;
    localparam apms_pwr_t po = APMS_PWR_ON;
    localparam apms_pwr_t pw = APMS_PWR_WAKING;
    logic sys_clk, reset, ext_ref, sample_pulse, conv_done, conv_abort, sample_early;
    wire logic cs_n, sclk, din;
    apms_pwr_t power_state;
    logic [7:0] ctrl_reg, b;
    logic [31:0] rb;
    logic [11:0] obs;
    logic [11:0] q[$];
    int seed = 9338, errors = 0, n_compared = 0;
    logic [1:0] md[9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3};
    int n[9] = '{16, 4, 16, 16, 16, 16, 16, 16, 16};
    // Transfer two cannot finish a wake from shutdown; transfer three waits it out.
    int w[9] = '{520, 0, 0, 260, 0, 520, 120, 0, 120};
    logic ea[9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    apms_pwr_t de[9] = '{po, pf, pw, po, pf, pf, po, ps, ps};
    apms_pwr_t af[9] = '{pf, pf, pw, po, pf, pf, pf, ps, ps};
    apms_host_model host (.sys_clk, .cs_n, .sclk, .din);
    apms_seq dut (.sys_clk, .reset, .ce(1'b1), .cs_n, .sclk, .din, .ext_ref, .power_state, .ctrl_reg,
        .power_mode_hi(), .power_mode_lo(), .sample_pulse, .conv_done, .conv_abort, .sample_early);
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Only one pulse can stand in a cycle, so each event takes one note.
    always @(negedge sys_clk) begin
        if ((sample_pulse | conv_done | conv_abort) === 1'b1) begin
            obs = conv_done ? {2'h2, power_state, ctrl_reg} :
                conv_abort ? {2'h3, power_state, 8'h00} : {3'h2, sample_early, 8'h00};
            if (q.size() == 0) chk("unexpected", obs, 12'hfff);
            else chk("event", obs, q.pop_front());
        end
    end
    initial begin
        reset = 1'b1;
        ext_ref = 1'b0;
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        chk("reset_state", 12'(power_state), 12'(pf));
        chk("reset_ctrl", 12'(ctrl_reg), 12'h000);
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            ext_ref = (i == 6);
            rb = $random(seed);
            b = (i == 0) ? 8'h00 : {rb[7:2], md[i]};
            q.push_back({3'h2, ea[i], 8'h00});
            q.push_back((n[i] == 16) ? {2'h2, de[i], b} : {2'h3, pf, 8'h00});
            host.xfer(b, n[i], w[i], (i == 0) ? 8'h00 : rb[15:8]);
            repeat (10) @(negedge sys_clk);
            chk("state_after", 12'(power_state), 12'(af[i]));
        end
        chk("queue_left", 12'(q.size()), 12'h000);
        finish_test();
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        finish_test();
    end
endmodule // tb_adc_power_mode_sequencer
`default_nettype wire
